// File: design/flash_cfg_pkg.sv
// Constants and types for the flash configuration and protection registers.
//Contract
//- Four-bit protect code selects top/bottom 64KB blocks.
//- Refuse program/erase inside protected range.
//- Program-paused flag bit 2 set/cleared by suspend/resume.
//- Erase-paused flag bit 3 set/cleared by suspend/resume.
//- Row lock bits 7..4 reset zero, one-time set.
//- Locked row refuses programming; unlocked row permitted.
//- Working copy loads from persistent copy at power-up.
//- 65h writes persistent, C0h/63h write working copy.
//- Bit 7 picks hold or reset role.
//- Quad or four-line mode forces data line 3.
//- Bits 6..3 give dummy cycles 1 to 15.
//- Zero dummy field uses per-command default count.
//- Bit 2 enables wrap within aligned burst window.
//- Wrap disabled: reads run through whole array.
//- Bits 1..0 select burst 8/16/32/64 bytes.
package flash_cfg_pkg;
  localparam logic [7:0] CMD_SET_RP_NV = 8'h65;
  localparam logic [7:0] CMD_SET_RP_V1 = 8'hc0;
  localparam logic [7:0] CMD_SET_RP_V2 = 8'h63;
  localparam logic [7:0] CMD_WR_FUNC = 8'h42;
  localparam logic [7:0] CMD_WR_EN = 8'h06;
  localparam logic [7:0] CMD_RD_RP = 8'h61;
  localparam logic [7:0] CMD_RD_FUNC = 8'h48;
  localparam logic [7:0] FUNC_RESET = 8'h00;
  localparam logic [7:0] RP_RESET = 8'h00;
  localparam int FR_PROG_PAUSED = 2;
  localparam int FR_ERASE_PAUSED = 3;
  localparam int FR_LOCK_LSB = 4;
  localparam int FR_LOCK_MSB = 7;
  localparam int RP_ROLE = 7;
  localparam int RP_DUM_MSB = 6;
  localparam int RP_DUM_LSB = 3;
  localparam int RP_WRAP = 2;
  localparam int RP_BL_MSB = 1;
  localparam int BURST_MIN_LOG2 = 3;
  localparam int BLOCK_LOG2 = 16;
  localparam logic [3:0] DUM_SINGLE = 4'h8;
  localparam logic [3:0] DUM_QUAD = 4'h6;
  localparam logic [3:0] DUM_DUAL_IO = 4'h4;
  typedef enum logic [2:0] {
    RK_FAST_SINGLE,
    RK_DUAL_OUT,
    RK_QUAD_OUT,
    RK_QUAD_IO,
    RK_FAST_FOUR,
    RK_DUAL_IO
  } read_kind_type;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_OPC,
    ST_DATA,
    ST_OUT,
    ST_DONE,
    ST_SKIP
  } spi_state_type;
endpackage

// File: design/block_protect_decode.sv
// Decodes the protect code into a hit test for one address.
`timescale 1ns/100ps
module block_protect_decode #(
  parameter int ADDR_W = 20
) (
  input wire logic [3:0] i_code,
  input wire logic [ADDR_W-1:0] i_addr,
  output logic o_hit
);
  localparam int BW = ADDR_W - flash_cfg_pkg::BLOCK_LOG2;
  localparam int NB = 1 << BW;
  if (BW < 1 || BW > 8)
  begin
    $error("block_protect_decode: unsupported ADDR_W");
  end
  always_comb
  begin
    int blk;
    int n;
    blk = int'(i_addr[ADDR_W-1:flash_cfg_pkg::BLOCK_LOG2]);
    n = 0;
    o_hit = 1'b0;
    if (i_code >= 4'h1 && i_code <= 4'h4)
    begin
      n = 1 << (int'(i_code) - 1);
      o_hit = (blk >= NB - n);
    end
    else if (i_code >= 4'hb && i_code <= 4'he)
    begin
      n = 1 << (14 - int'(i_code));
      o_hit = (blk < n);
    end
    else if (i_code >= 4'h5 && i_code <= 4'ha)
    begin
      o_hit = 1'b1;
    end
  end
endmodule

// File: design/dummy_default_select.sv
// Selects the dummy cycle count for a read command.
`timescale 1ns/100ps
module dummy_default_select (
  input wire logic [3:0] i_field,
  input wire flash_cfg_pkg::read_kind_type i_kind,
  output logic [3:0] o_count
);
  always_comb
  begin
    o_count = i_field;
    if (i_field == 4'h0)
    begin
      case (i_kind)
        flash_cfg_pkg::RK_QUAD_IO,
        flash_cfg_pkg::RK_FAST_FOUR:
          o_count = flash_cfg_pkg::DUM_QUAD;
        flash_cfg_pkg::RK_DUAL_IO:
          o_count = flash_cfg_pkg::DUM_DUAL_IO;
        default:
          o_count = flash_cfg_pkg::DUM_SINGLE;
      endcase
    end
  end
endmodule

// File: design/flash_cfg_regs.sv
// Configuration and protection registers reached over serial commands.
`timescale 1ns/100ps
module flash_cfg_regs #(
  parameter int ADDR_W = 20,
  parameter logic [7:0] NV_INIT = 8'h00
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_sck,
  input wire logic i_cs_b,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe,
  input wire logic [3:0] i_protect_sel,
  input wire logic i_quad_lines_enable,
  input wire logic i_four_line_command_mode,
  input wire logic i_program_busy,
  input wire logic i_erase_busy,
  input wire logic i_suspend,
  input wire logic i_resume,
  input wire logic i_pe_req,
  input wire logic [ADDR_W-1:0] i_pe_addr,
  output logic o_pe_grant,
  output logic o_pe_refuse,
  input wire logic i_row_req,
  input wire logic [1:0] i_row_sel,
  output logic o_row_grant,
  output logic o_row_refuse,
  input wire logic i_read_start,
  input wire flash_cfg_pkg::read_kind_type i_read_kind,
  input wire logic [ADDR_W-1:0] i_seq_addr,
  output logic [ADDR_W-1:0] o_seq_next,
  output logic [3:0] o_dummy_cycles,
  output logic o_pin_is_hold,
  output logic o_pin_is_reset,
  output logic o_pin_is_io3,
  output logic [7:0] o_func_reg,
  output logic [7:0] o_rp_working,
  output logic [7:0] o_rp_persistent
);
  typedef struct packed {
    flash_cfg_pkg::spi_state_type st;
    logic sck1;
    logic sck2;
    logic sck_p;
    logic cs1;
    logic cs2;
    logic si1;
    logic si2;
    logic [7:0] sh;
    logic [2:0] cnt;
    logic [7:0] opc;
    logic [7:0] dat;
    logic so;
    logic wel;
    logic loaded;
    logic [7:0] nv;
    logic [7:0] work;
    logic [7:0] snap;
    logic prog_paused;
    logic erase_paused;
    logic [3:0] lock;
    logic pe_g;
    logic pe_r;
    logic row_g;
    logic row_r;
    logic [ADDR_W-1:0] nxt;
    logic [3:0] dum;
  } state_type;

  localparam state_type RST = '{
    st: flash_cfg_pkg::ST_IDLE, sck1: 1'b0, sck2: 1'b0, sck_p: 1'b0,
    cs1: 1'b1, cs2: 1'b1, si1: 1'b0, si2: 1'b0, sh: 8'h00,
    cnt: 3'h0, opc: 8'h00, dat: 8'h00, so: 1'b0, wel: 1'b0,
    loaded: 1'b0, nv: NV_INIT, work: flash_cfg_pkg::RP_RESET,
    snap: flash_cfg_pkg::RP_RESET, prog_paused: 1'b0,
    erase_paused: 1'b0,
    lock: 4'h0, pe_g: 1'b0, pe_r: 1'b0, row_g: 1'b0, row_r: 1'b0,
    nxt: '0, dum: 4'h0};

  if (ADDR_W < 17 || ADDR_W > 24)
  begin
    $error("flash_cfg_regs: unsupported ADDR_W");
  end

  logic rst1_q;
  logic rst_b;
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rst1_q <= 1'b0;
      rst_b <= 1'b0;
    end
    else
    begin
      rst1_q <= 1'b1;
      rst_b <= rst1_q;
    end
  end

  state_type q;
  state_type d;
  logic pe_hit;
  logic [3:0] dum_sel;
  logic [7:0] func_val;
  logic [ADDR_W-1:0] mask;

  block_protect_decode #(.ADDR_W(ADDR_W)) u_prot (
    .i_code(i_protect_sel),
    .i_addr(i_pe_addr),
    .o_hit(pe_hit)
  );

  dummy_default_select u_dum (
    .i_field(q.snap[flash_cfg_pkg::RP_DUM_MSB:flash_cfg_pkg::RP_DUM_LSB]),
    .i_kind(i_read_kind),
    .o_count(dum_sel)
  );

  assign func_val = {q.lock, q.erase_paused, q.prog_paused, 2'b00};
  assign mask = ADDR_W'((1 << (flash_cfg_pkg::BURST_MIN_LOG2
    + int'(q.snap[flash_cfg_pkg::RP_BL_MSB:0]))) - 1);

  always_comb
  begin
    logic rise;
    logic fall;
    logic [7:0] byte_in;
    rise = q.sck2 && !q.sck_p;
    fall = !q.sck2 && q.sck_p;
    byte_in = {q.sh[6:0], q.si2};
    d = q;
    d.sck1 = i_sck;
    d.sck2 = q.sck1;
    d.sck_p = q.sck2;
    d.cs1 = i_cs_b;
    d.cs2 = q.cs1;
    d.si1 = i_si;
    d.si2 = q.si1;
    if (!q.loaded)
    begin
      d.work = q.nv;
      d.snap = q.nv;
      d.loaded = 1'b1;
    end
    if (q.cs2)
    begin
      d.st = flash_cfg_pkg::ST_IDLE;
      d.cnt = 3'h0;
      if (q.st == flash_cfg_pkg::ST_DONE)
      begin
        if (q.opc == flash_cfg_pkg::CMD_SET_RP_NV && q.wel)
        begin
          d.nv = q.dat;
          d.wel = 1'b0;
        end
        else if (q.opc == flash_cfg_pkg::CMD_WR_FUNC && q.wel)
        begin
          d.lock = q.lock | q.dat[flash_cfg_pkg::FR_LOCK_MSB:
            flash_cfg_pkg::FR_LOCK_LSB];
          d.wel = 1'b0;
        end
        else if (q.opc == flash_cfg_pkg::CMD_SET_RP_V1
          || q.opc == flash_cfg_pkg::CMD_SET_RP_V2)
        begin
          d.work = q.dat;
        end
      end
    end
    else
    begin
      case (q.st)
        flash_cfg_pkg::ST_IDLE:
          d.st = flash_cfg_pkg::ST_OPC;
        flash_cfg_pkg::ST_OUT:
          if (fall)
          begin
            d.so = q.sh[7];
            d.sh = {q.sh[6:0], 1'b0};
          end
        default:
          ;
      endcase
      if (rise && (q.st == flash_cfg_pkg::ST_OPC
        || q.st == flash_cfg_pkg::ST_DATA))
      begin
        d.sh = byte_in;
        d.cnt = q.cnt + 3'h1;
        if (q.cnt == 3'h7 && q.st == flash_cfg_pkg::ST_DATA)
        begin
          d.dat = byte_in;
          d.st = flash_cfg_pkg::ST_DONE;
        end
        else if (q.cnt == 3'h7)
        begin
          d.opc = byte_in;
          d.st = flash_cfg_pkg::ST_SKIP;
          if (byte_in == flash_cfg_pkg::CMD_WR_EN)
          begin
            d.wel = 1'b1;
          end
          else if (byte_in == flash_cfg_pkg::CMD_RD_RP)
          begin
            d.sh = q.work;
            d.st = flash_cfg_pkg::ST_OUT;
          end
          else if (byte_in == flash_cfg_pkg::CMD_RD_FUNC)
          begin
            d.sh = func_val;
            d.st = flash_cfg_pkg::ST_OUT;
          end
          else if (byte_in == flash_cfg_pkg::CMD_SET_RP_NV
            || byte_in == flash_cfg_pkg::CMD_SET_RP_V1
            || byte_in == flash_cfg_pkg::CMD_SET_RP_V2
            || byte_in == flash_cfg_pkg::CMD_WR_FUNC)
          begin
            d.st = flash_cfg_pkg::ST_DATA;
          end
        end
      end
    end
    if (i_suspend && i_program_busy)
    begin
      d.prog_paused = 1'b1;
    end
    else if (i_resume && q.prog_paused)
    begin
      d.prog_paused = 1'b0;
    end
    if (i_suspend && i_erase_busy)
    begin
      d.erase_paused = 1'b1;
    end
    else if (i_resume && q.erase_paused)
    begin
      d.erase_paused = 1'b0;
    end
    d.pe_g = i_pe_req && !pe_hit;
    d.pe_r = i_pe_req && pe_hit;
    d.row_g = i_row_req && !q.lock[i_row_sel];
    d.row_r = i_row_req && q.lock[i_row_sel];
    if (i_read_start)
    begin
      d.snap = q.work;
    end
    if (q.snap[flash_cfg_pkg::RP_WRAP])
    begin
      d.nxt = (i_seq_addr & ~mask) | ((i_seq_addr + 1'b1) & mask);
    end
    else
    begin
      d.nxt = i_seq_addr + 1'b1;
    end
    d.dum = dum_sel;
  end

  always_ff @(posedge i_mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q <= RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign o_so = q.so;
  assign o_so_oe = (q.st == flash_cfg_pkg::ST_OUT) && !q.cs2;
  assign o_pe_grant = q.pe_g;
  assign o_pe_refuse = q.pe_r;
  assign o_row_grant = q.row_g;
  assign o_row_refuse = q.row_r;
  assign o_seq_next = q.nxt;
  assign o_dummy_cycles = q.dum;
  assign o_func_reg = func_val;
  assign o_rp_working = q.work;
  assign o_rp_persistent = q.nv;
  assign o_pin_is_io3 = i_quad_lines_enable
    || i_four_line_command_mode;
  assign o_pin_is_reset = !o_pin_is_io3
    && q.work[flash_cfg_pkg::RP_ROLE];
  assign o_pin_is_hold = !o_pin_is_io3
    && !q.work[flash_cfg_pkg::RP_ROLE];

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!rst_b);

  chk_protect_refuse: assert property (
    i_pe_req && pe_hit |=> o_pe_refuse && !o_pe_grant)
    else $error("protected request not refused");
  chk_prog_pause_set: assert property (
    i_suspend && i_program_busy
    |=> o_func_reg[flash_cfg_pkg::FR_PROG_PAUSED])
    else $error("program paused flag not set");
  chk_erase_pause_clear: assert property (
    i_resume && !i_suspend && q.erase_paused
    |=> !o_func_reg[flash_cfg_pkg::FR_ERASE_PAUSED])
    else $error("erase paused flag not cleared");
  chk_lock_sticky: assert property (
    q.loaded && !$stable(q.lock) |-> (q.lock & $past(q.lock)) == $past(q.lock))
    else $error("row lock bit fell");
  chk_row_lock: assert property (
    i_row_req && q.lock[i_row_sel] |=> o_row_refuse && !o_row_grant)
    else $error("locked row programming not refused");
  chk_nv_isolated: assert property (
    q.loaded && !$stable(q.nv) |-> $stable(q.work))
    else $error("persistent write touched working copy");
  chk_pin_role: assert property (
    !i_quad_lines_enable && !i_four_line_command_mode
    |-> o_pin_is_reset == q.work[7] && o_pin_is_hold == !q.work[7])
    else $error("pin role mismatch");
  chk_io3_force: assert property (
    i_quad_lines_enable |-> o_pin_is_io3 && !o_pin_is_reset && !o_pin_is_hold)
    else $error("data line 3 not forced");
  chk_snap_hold: assert property (
    q.loaded && !i_read_start |=> $stable(q.snap))
    else $error("read parameters changed mid read");
  chk_wrap_window: assert property (
    q.snap[2] |=> (o_seq_next & ~$past(mask)) ==
      ($past(i_seq_addr) & ~$past(mask)))
    else $error("wrap left aligned window");
  chk_dummy_count: assert property (
    q.snap[6:3] != 4'h0 |=> o_dummy_cycles == $past(q.snap[6:3]))
    else $error("dummy count mismatch");

  cov_refuse: cover property (i_pe_req && pe_hit ##1 o_pe_refuse);
  cov_vol_write: cover property (!$stable(q.work) && q.loaded);
  cov_suspend: cover property (q.prog_paused ##[1:50] !q.prog_paused);
endmodule

// File: testbench/spi_host_model.sv
// Host-side serial controller model that issues register commands.
`timescale 1ns/100ps
module spi_host_model (
  output logic o_sck,
  output logic o_cs_b,
  output logic o_si,
  input wire logic i_so
);
  initial
  begin
    o_sck = 1'b0;
    o_cs_b = 1'b1;
    o_si = 1'b0;
  end
  // Shifts an opcode and n data bits, then reads a byte back if rd is set.
  task automatic xfer(input logic [7:0] op, input logic [7:0] d,
    input int n, input bit rd, output logic [7:0] q);
    logic [15:0] w;
    w = {op, d};
    q = 8'h00;
    o_cs_b = 1'b0;
    #80;
    for (int i = 0; i < 8 + n; i++)
    begin
      o_si = w[15-i];
      #80 o_sck = 1'b1;
      #80 o_sck = 1'b0;
    end
    for (int i = 0; i < (rd ? 8 : 0); i++)
    begin
      #80 q = {q[6:0], i_so};
      o_sck = 1'b1;
      #80 o_sck = 1'b0;
    end
    #80 o_cs_b = 1'b1;
    o_si = ~o_si;
    #240;
  endtask
  // Writes a register, preceded by a write enable when we is set.
  task automatic wr(input logic [7:0] op, input logic [7:0] v, input bit we);
    logic [7:0] q;
    if (we)
      xfer(8'h06, 8'h00, 0, 0, q);
    xfer(op, v, 8, 0, q);
  endtask
endmodule

// File: testbench/tb_serial_flash_config_protect_regs.sv
// Self-checking bench for the configuration and protection registers.
`timescale 1ns/100ps
module tb_serial_flash_config_protect_regs;
  localparam logic [7:0] NV0 = 8'ha5;
  logic i_mclk, i_rst_b, i_sck, i_cs_b, i_si, o_so, o_so_oe;
  logic i_quad_lines_enable, i_four_line_command_mode;
  logic i_program_busy, i_erase_busy, i_suspend, i_resume;
  logic i_pe_req, o_pe_grant, o_pe_refuse;
  logic i_row_req, o_row_grant, o_row_refuse, i_read_start;
  logic o_pin_is_hold, o_pin_is_reset, o_pin_is_io3;
  logic [3:0] i_protect_sel, o_dummy_cycles;
  logic [1:0] i_row_sel;
  logic [19:0] i_pe_addr, i_seq_addr, o_seq_next;
  logic [7:0] o_func_reg, o_rp_working, o_rp_persistent, d;
  flash_cfg_pkg::read_kind_type i_read_kind;
  int rp_w, rp_nv, fr, n_errors, samples_checked, b, io;
  flash_cfg_regs #(.ADDR_W(20), .NV_INIT(NV0)) dut (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_sck(i_sck), .i_cs_b(i_cs_b),
    .i_si(i_si), .o_so(o_so), .o_so_oe(o_so_oe),
    .i_protect_sel(i_protect_sel),
    .i_quad_lines_enable(i_quad_lines_enable),
    .i_four_line_command_mode(i_four_line_command_mode),
    .i_program_busy(i_program_busy), .i_erase_busy(i_erase_busy),
    .i_suspend(i_suspend), .i_resume(i_resume), .i_pe_req(i_pe_req),
    .i_pe_addr(i_pe_addr), .o_pe_grant(o_pe_grant),
    .o_pe_refuse(o_pe_refuse), .i_row_req(i_row_req),
    .i_row_sel(i_row_sel), .o_row_grant(o_row_grant),
    .o_row_refuse(o_row_refuse), .i_read_start(i_read_start),
    .i_read_kind(i_read_kind), .i_seq_addr(i_seq_addr),
    .o_seq_next(o_seq_next), .o_dummy_cycles(o_dummy_cycles),
    .o_pin_is_hold(o_pin_is_hold), .o_pin_is_reset(o_pin_is_reset),
    .o_pin_is_io3(o_pin_is_io3), .o_func_reg(o_func_reg),
    .o_rp_working(o_rp_working), .o_rp_persistent(o_rp_persistent));
  spi_host_model host (.o_sck(i_sck), .o_cs_b(i_cs_b), .o_si(i_si),
    .i_so(o_so));
  initial
  begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  task automatic check(input string nm, input logic [19:0] seen,
    input logic [19:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk_regs;
    logic [7:0] v;
    check("working", o_rp_working, rp_w);
    check("persistent", o_rp_persistent, rp_nv);
    check("function", o_func_reg, fr);
    fork
      host.xfer(8'h61, 8'h00, 0, 1, v);
      begin
        #1600;
        check("so_oe_on", o_so_oe, 1);
      end
    join
    check("rp_back", v, rp_w);
    check("so_oe_off", o_so_oe, 0);
    host.xfer(8'h48, 8'h00, 0, 1, v);
    check("fr_back", v, fr);
  endtask
  task automatic step;
    @(posedge i_mclk);
    #1;
  endtask
  task automatic row(input int r);
    i_row_sel = r[1:0];
    i_row_req = 1'b1;
    step;
    check("row_grant", o_row_grant, !fr[4+r]);
    check("row_refuse", o_row_refuse, fr[4+r]);
  endtask
  function automatic int nxt(input int a, input int p);
    int w;
    w = 8 << p[1:0];
    if (p[2])
      return (a & ~(w - 1)) | ((a + 1) & (w - 1));
    return (a + 1) & 32'hfffff;
  endfunction
  initial
  begin
    #500000;
    n_errors++;
    print_verdict;
  end
  initial
  begin
    {i_rst_b, i_protect_sel, i_quad_lines_enable} = '0;
    {i_four_line_command_mode, i_program_busy, i_erase_busy} = '0;
    {i_suspend, i_resume, i_pe_req, i_pe_addr, i_row_req} = '0;
    {i_row_sel, i_read_start, i_seq_addr} = '0;
    i_read_kind = flash_cfg_pkg::RK_FAST_SINGLE;
    void'($urandom(32'hb6c5332b));
    rp_nv = NV0;
    rp_w = NV0;
    fr = 0;
    repeat (5) @(posedge i_mclk);
    #1 i_rst_b = 1'b1;
    repeat (10) step;
    chk_regs;
    d = $urandom;
    host.wr(8'h65, d, 0);
    chk_regs;
    host.wr(8'h65, d, 1);
    rp_nv = d;
    chk_regs;
    for (int r = 0; r < 4; r++)
      row(r);
    i_row_req = 1'b0;
    host.wr(8'h42, 8'hf0, 0);
    chk_regs;
    d = $urandom | 8'h30;
    host.wr(8'h42, d, 1);
    fr = d & 8'hf0;
    host.wr(8'h42, 8'h00, 1);
    chk_regs;
    for (int r = 0; r < 4; r++)
      row(r);
    i_row_req = 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      i_program_busy = (k == 0);
      i_erase_busy = (k == 1);
      i_suspend = 1'b1;
      step;
      i_suspend = 1'b0;
      step;
      fr = fr | (4 << k);
      chk_regs;
      i_resume = 1'b1;
      step;
      i_resume = 1'b0;
      step;
      fr = fr & ~(4 << k);
      chk_regs;
    end
    for (int c = 0; c < 16; c++)
      for (int k = 0; k < 16; k++)
      begin
        i_protect_sel = c[3:0];
        i_pe_addr = {k[3:0], 16'($urandom)};
        i_pe_req = 1'b1;
        step;
        b = (c == 0 || c == 15) ? 0 : (c < 5) ? (k >= 16 - (1 << (c - 1))) :
          (c > 10) ? (k < (1 << (14 - c))) : 1;
        check("pe_refuse", o_pe_refuse, b);
        check("pe_grant", o_pe_grant, !b);
      end
    i_pe_req = 1'b0;
    for (int f = 0; f < 16; f++)
    begin
      d = {1'($urandom), f[3:0], 3'($urandom)};
      host.wr((f[0] ? 8'hc0 : 8'h63), d, 0);
      rp_w = d;
      i_quad_lines_enable = 1'($urandom);
      i_four_line_command_mode = 1'($urandom);
      io = i_quad_lines_enable | i_four_line_command_mode;
      step;
      check("io3", o_pin_is_io3, io);
      check("hold", o_pin_is_hold, !io && !d[7]);
      check("reset", o_pin_is_reset, !io && d[7]);
      for (int k = 0; k < 6; k++)
      begin
        i_read_kind = flash_cfg_pkg::read_kind_type'(k);
        i_seq_addr = 20'($urandom);
        i_read_start = 1'b1;
        step;
        i_read_start = 0;
        step;
        b = f != 0 ? f : k < 3 ? 8 : k < 5 ? 6 : 4;
        check("dummy", o_dummy_cycles, b);
        check("next", o_seq_next, nxt(i_seq_addr, d));
      end
    end
    chk_regs;
    print_verdict;
  end
endmodule
